// ==== logic/dsad_decode.v ====
// Data space decode: read and write address generators, 16 KB word memory
// How it works
// - One linear 16-bit-wide data space, separate
// - Independent read and write address generator ports
// - 16-bit byte effective address, 64 KB range
// - Bit 15 low selects implemented memory
// - Bit 15 high selects program space window
// - 16 KB implemented at bottom of space
// - Reads in the lower half above implemented memory return zero
// - Storage word aligned, addresses resolve bytes
// - Even address low byte, odd high
`timescale 1ns/10ps
`include "dsad_defines.vh"

// Splits one byte effective address into region, word index and lane
module dsad_ea_split #(
    parameter AW     = `DSAD_AW,
    parameter IDX_W  = `DSAD_WIDX_W
) (
    // Byte effective address
    input  wire [AW-1:0]    effective_address,
    // Decoded fields
    output wire             window,
    output wire             in_ram,
    output wire [IDX_W-1:0] idx,
    output wire             odd
);

    // Upper half belongs to the program space window
    assign window = effective_address[`DSAD_WINDOW_BIT];

    // Only the bottom of the lower half is backed by storage
    assign in_ram = ~window &&
                    (effective_address < `DSAD_RAM_BYTES);

    // Bit 0 picks the lane; the word index ignores it
    assign idx = effective_address[IDX_W:1];

    assign odd = effective_address[`DSAD_LANE_BIT];

endmodule

// One byte lane of the implemented memory
module dsad_lane_ram #(
    parameter LANE_W = `DSAD_LANE_W,
    parameter DEPTH  = `DSAD_RAM_WORDS,
    parameter IDX_W  = `DSAD_WIDX_W
) (
    // Clock and reset
    input  wire              clk_sys,
    input  wire              rst,
    // Write side
    input  wire              wr_stb,
    input  wire [IDX_W-1:0]  wr_idx,
    input  wire [LANE_W-1:0] wr_lane,
    // Read side
    input  wire [IDX_W-1:0]  rd_idx,
    output wire [LANE_W-1:0] rd_lane
);

    reg  [LANE_W-1:0] cell_ff [0:DEPTH-1];
    integer           k;

    // A read in the cycle of a write to the same word sees old data
    assign rd_lane = cell_ff[rd_idx];

    // Cleared on reset so reads are defined; costs reset fan-out
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                cell_ff[k] <= {LANE_W{1'b0}};
            end
        end else if (wr_stb) begin
            cell_ff[wr_idx] <= wr_lane;
        end
    end

endmodule

module dsad_decode (
    // Clock and reset
    input  wire                    clk_sys,
    input  wire                    rst,
    // Read address generator
    input  wire                    rd_en,
    input  wire [`DSAD_AW-1:0]     rd_effective_address,
    input  wire                    rd_byte,
    output reg  [`DSAD_DW-1:0]     rd_data_ff,
    output reg                     rd_valid_ff,
    // Program space window, combinational forward of the read
    output wire                    pgm_win_req,
    output wire [`DSAD_AW-2:0]     pgm_win_offset,
    input  wire [`DSAD_DW-1:0]     pgm_win_data,
    // Write address generator
    input  wire                    wr_en,
    input  wire [`DSAD_AW-1:0]     wr_effective_address,
    input  wire                    wr_byte,
    input  wire [`DSAD_DW-1:0]     wr_data
);

    // Read address fields
    wire                     rd_window;
    wire                     rd_in_ram;
    wire [`DSAD_WIDX_W-1:0]  rd_idx;
    wire                     rd_odd;
    // Write address fields
    wire                     wr_window;
    wire                     wr_in_ram;
    wire [`DSAD_WIDX_W-1:0]  wr_idx;
    wire                     wr_odd;
    // Lane strobes and data
    wire                     wr_take;
    wire                     wr_lo_stb;
    wire                     wr_hi_stb;
    wire [`DSAD_LANE_W-1:0]  wr_lo_lane;
    wire [`DSAD_LANE_W-1:0]  wr_hi_lane;
    wire [`DSAD_LANE_W-1:0]  rd_lo_lane;
    wire [`DSAD_LANE_W-1:0]  rd_hi_lane;
    // Read data assembly
    reg  [`DSAD_DW-1:0]      rd_word;
    reg  [`DSAD_DW-1:0]      nxt_rd_data;
    reg                      nxt_rd_valid;

    // Independent decode for each address generator
    dsad_ea_split u_dsad_ea_split_rd (
        .effective_address (rd_effective_address),
        .window            (rd_window),
        .in_ram            (rd_in_ram),
        .idx               (rd_idx),
        .odd               (rd_odd)
    );

    dsad_ea_split u_dsad_ea_split_wr (
        .effective_address (wr_effective_address),
        .window            (wr_window),
        .in_ram            (wr_in_ram),
        .idx               (wr_idx),
        .odd               (wr_odd)
    );

    // Writes outside memory or into the window are dropped
    assign wr_take = wr_en && wr_in_ram && ~wr_window;

    // A byte write strobes one lane only, the other keeps its value
    assign wr_lo_stb = wr_take && (!wr_byte || !wr_odd);
    assign wr_hi_stb = wr_take && (!wr_byte || wr_odd);

    // Byte data always arrives in the low byte of the write bus
    assign wr_lo_lane = wr_data[`DSAD_LO_BYTE];
    assign wr_hi_lane = wr_byte ? wr_data[`DSAD_LO_BYTE]
                                : wr_data[`DSAD_HI_BYTE];

    // Even byte address holds the low lane
    dsad_lane_ram u_dsad_lane_ram_lo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_stb  (wr_lo_stb),
        .wr_idx  (wr_idx),
        .wr_lane (wr_lo_lane),
        .rd_idx  (rd_idx),
        .rd_lane (rd_lo_lane)
    );

    // Odd byte address holds the high lane
    dsad_lane_ram u_dsad_lane_ram_hi (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_stb  (wr_hi_stb),
        .wr_idx  (wr_idx),
        .wr_lane (wr_hi_lane),
        .rd_idx  (rd_idx),
        .rd_lane (rd_hi_lane)
    );

    // Window read is a pass-through; the source must answer in the cycle
    assign pgm_win_req    = rd_en && rd_window;
    assign pgm_win_offset = rd_effective_address[`DSAD_AW-2:0];

    // Source word for the read
    always @* begin
        if (rd_window) begin
            rd_word = pgm_win_data;
        end else if (rd_in_ram) begin
            rd_word = {rd_hi_lane, rd_lo_lane};
        end else begin
            rd_word = `DSAD_ZERO_WORD;
        end
    end

    // Lane selection; byte reads are right-justified
    always @* begin
        nxt_rd_valid = rd_en;
        nxt_rd_data  = rd_data_ff;
        if (rd_en) begin
            if (!rd_byte) begin
                nxt_rd_data = rd_word;
            end else if (rd_odd) begin
                nxt_rd_data = {`DSAD_ZERO_BYTE, rd_word[`DSAD_HI_BYTE]};
            end else begin
                nxt_rd_data = {`DSAD_ZERO_BYTE, rd_word[`DSAD_LO_BYTE]};
            end
        end
    end

    // Read data holds until the next read
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data_ff  <= `DSAD_ZERO_WORD;
            rd_valid_ff <= `DSAD_VALID_IDLE;
        end else begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

endmodule

// Notes on use
// Word access at an odd address uses the containing word.
// Memory reset is costly in area but keeps every read defined.
// The window source sits outside; it is not registered here,
// so its access time adds to the read address path.

// ==== logic/dsad_defines.vh ====
// Constants for the data space address decode block
`ifndef DSAD_DEFINES_VH
`define DSAD_DEFINES_VH
`define DSAD_AW           16
`define DSAD_DW           16
`define DSAD_WINDOW_BIT   15
`define DSAD_LANE_BIT     0
`define DSAD_RAM_BYTES    16'h4000
`define DSAD_RAM_WORDS    14'h2000
`define DSAD_WIDX_W       13
`define DSAD_LANE_W       8
`define DSAD_ZERO_WORD    16'h0000
`define DSAD_ZERO_BYTE    8'h00
`define DSAD_VALID_IDLE   1'b0
`define DSAD_LO_BYTE      7:0
`define DSAD_HI_BYTE      15:8
`endif

// ==== verification/dsad_asserts.sv ====
// Port checker for the data space decode
`timescale 1ns/10ps
module dsad_asserts (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // Read generator
    input wire        rd_en,
    input wire        rd_byte,
    input wire [15:0] rd_effective_address,
    input wire [15:0] rd_data_ff,
    input wire        rd_valid_ff,
    // Program space window
    input wire        pgm_win_req,
    input wire [14:0] pgm_win_offset,
    input wire [15:0] pgm_win_data
);
    reg  [15:0] pd_ff;
    wire [15:0] a = rd_effective_address;
    wire        w = rd_en & a[15] & rd_byte;
    always @(posedge clk_sys) pd_ff <= pgm_win_data;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_hole; rd_en && a[15:14] == 2'b01; endsequence
    sequence s_byte; rd_en && rd_byte; endsequence
    property p_vld; rd_en |=> rd_valid_ff; endproperty
    a_vld: assert property (p_vld) else $error("no valid");
    property p_idle; !rd_en |=> !rd_valid_ff; endproperty
    a_idle: assert property (p_idle) else $error("stray valid");
    property p_req; pgm_win_req == (rd_en && a[15]); endproperty
    a_req: assert property (p_req) else $error("window select");
    property p_off; pgm_win_req |-> pgm_win_offset == a[14:0]; endproperty
    a_off: assert property (p_off) else $error("window offset");
    property p_hole; s_hole |=> rd_data_ff == 16'h0000; endproperty
    a_hole: assert property (p_hole) else $error("hole not zero");
    property p_word; rd_en && a[15] && !rd_byte |=> rd_data_ff == pd_ff; endproperty
    a_word: assert property (p_word) else $error("window word");
    property p_odd; w && a[0] |=> rd_data_ff == {8'h00, pd_ff[15:8]}; endproperty
    a_odd: assert property (p_odd) else $error("odd lane");
    property p_even; w && !a[0] |=> rd_data_ff == {8'h00, pd_ff[7:0]}; endproperty
    a_even: assert property (p_even) else $error("even lane");
    property p_just; s_byte |=> rd_data_ff[15:8] == 8'h00; endproperty
    a_just: assert property (p_just) else $error("byte not right-justified");
endmodule

// ==== verification/dsad_window_model.sv ====
// Program space window source
`timescale 1ns/10ps
module dsad_window_model (
    // Request from the decode
    input  wire        pgm_win_req,
    input  wire [14:0] pgm_win_offset,
    // Word returned
    output wire [15:0] pgm_win_data
);
    // Inverted when idle so stale data never passes for an answer
    assign pgm_win_data = {1'b0, pgm_win_offset} ^ (pgm_win_req ? 16'h5a00 : 16'hffff);
endmodule

// ==== verification/data_space_address_decode_bench.sv ====
// Bench for the data space address decode
`timescale 1ns/10ps
module data_space_address_decode_bench;
    // Clock and reset
    reg         clk_sys  = 1'b0;
    reg         rst      = 1'b1;
    // Read generator
    reg         rd_en    = 1'b0;
    reg         rd_byte  = 1'b0;
    reg  [15:0] ra       = 16'h0000;
    // Write generator
    reg         wr_en    = 1'b0;
    reg         wr_byte  = 1'b0;
    reg  [15:0] wa       = 16'h0000;
    reg  [15:0] wd       = 16'h0000;
    // Design outputs
    wire [15:0] rd_data_ff;
    wire        rd_valid_ff;
    wire        pgm_win_req;
    wire [14:0] pgm_win_offset;
    wire [15:0] pgm_win_data;
    // Tallies
    integer     fails    = 0;
    integer     compares = 0;

    always #50 clk_sys = ~clk_sys;

    dsad_decode u_dsad_decode (
        .clk_sys              (clk_sys),
        .rst                  (rst),
        .rd_en                (rd_en),
        .rd_effective_address (ra),
        .rd_byte              (rd_byte),
        .rd_data_ff           (rd_data_ff),
        .rd_valid_ff          (rd_valid_ff),
        .pgm_win_req          (pgm_win_req),
        .pgm_win_offset       (pgm_win_offset),
        .pgm_win_data         (pgm_win_data),
        .wr_en                (wr_en),
        .wr_effective_address (wa),
        .wr_byte              (wr_byte),
        .wr_data              (wd)
    );

    dsad_window_model u_dsad_window_model (
        .pgm_win_req    (pgm_win_req),
        .pgm_win_offset (pgm_win_offset),
        .pgm_win_data   (pgm_win_data)
    );

    task wr;
        input [15:0] a;
        input [15:0] d;
        input        b;
        begin
            @(negedge clk_sys);
            wr_en   = 1'b1;
            wa      = a;
            wd      = d;
            wr_byte = b;
            @(negedge clk_sys);
            wr_en   = 1'b0;
        end
    endtask

    // Request stands over one rising edge; answer checked a half cycle on
    task rd;
        input [15:0] a;
        input        b;
        input [15:0] e;
        begin
            @(negedge clk_sys);
            rd_en    = 1'b1;
            ra       = a;
            rd_byte  = b;
            @(negedge clk_sys);
            rd_en    = 1'b0;
            compares = compares + 1;
            if (rd_data_ff !== e || rd_valid_ff !== 1'b1) begin
                fails = fails + 1;
                $display("[ERR] %0t read %h got %h", $time, a, rd_data_ff);
            end
        end
    endtask

    task s_ram;
        begin
            wr(16'h0002, 16'h1234, 1'b0);
            wr(16'h0005, 16'h00ab, 1'b1);
            rd(16'h0003, 1'b0, 16'h1234);
            rd(16'h0002, 1'b1, 16'h0034);
            rd(16'h0003, 1'b1, 16'h0012);
            rd(16'h0004, 1'b0, 16'hab00);
            wr(16'h0006, 16'h1234, 1'b0);
            wr(16'h0006, 16'h00cd, 1'b1);
            rd(16'h0006, 1'b0, 16'h12cd);
        end
    endtask

    task s_edge;
        begin
            wr(16'h3ffe, 16'hbeef, 1'b0);
            wr(16'h4000, 16'h5555, 1'b0);
            rd(16'h3fff, 1'b0, 16'hbeef);
            rd(16'h4000, 1'b0, 16'h0000);
            rd(16'h7fff, 1'b1, 16'h0000);
            rd(16'h0000, 1'b0, 16'h0000);
        end
    endtask

    task s_win;
        begin
            rd(16'h8004, 1'b0, 16'h5a04);
            rd(16'h8005, 1'b1, 16'h005a);
            rd(16'h8004, 1'b1, 16'h0004);
            wr(16'h8002, 16'hffff, 1'b0);
            rd(16'h0002, 1'b0, 16'h1234);
        end
    endtask

    // Mid-run reset clears outputs and storage
    task s_rst;
        begin
            @(negedge clk_sys);
            rst = 1'b1;
            repeat (2) @(negedge clk_sys);
            compares = compares + 1;
            if (rd_data_ff !== 16'h0000 || rd_valid_ff !== 1'b0) begin
                fails = fails + 1;
                $display("[ERR] %0t outputs not cleared by reset", $time);
            end
            rst = 1'b0;
            rd(16'h0002, 1'b0, 16'h0000);
        end
    endtask

    task wrap_up;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        s_ram;
        s_edge;
        s_win;
        s_rst;
        wrap_up;
    end
endmodule
bind dsad_decode dsad_asserts u_dsad_asserts (.*);
